// ### core/output_state_event_logger.sv
// eight channel output driver with time stamped state logging
// Summary of operation
// R1: each of eight channels follows host command or measurement data.
// R2: an enabled channel turns its sink switch on; disabled leaves it off.
// R3: green indicator lit exactly while its channel switch is on.
// R4: records written only at start, stop, or output change.
// R5: recording begins only on host start command, or resumes from a restored recording state after power return.
// R6: each record holds one time stamp and all eight channel states.
// R7: new session appends after stored records; once full, the indefinite policy overwrites the oldest.
// R8: end policy chosen before start: stop when full or indefinite.
// R9: log store is 512 KB flash holding up to 30000 records.
// R10: host reads all records, records in a time span, or status.
// R11: delete command erases every stored record.
// R12: after power loss, prior state including recording restores itself.
// R13: change detected by comparing outputs with last recorded state.
`timescale 1ns/1ps
`default_nettype none
module output_state_event_logger
  import output_state_event_logger_pkg::*;
#(
  parameter int MAX_REC = MAX_RECORDS,
  parameter int LOG_FIFO_DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // host commands
  input wire logic cmd_valid,
  input wire cmd_s cmd,
  output logic cmd_ready_q,
  // measurement data and time base
  input wire logic meas_valid,
  input wire chan_t meas_bits,
  input wire stamp_t time_now,
  // channel drive and indicators
  output chan_t channel_on_q,
  output chan_t led_on_q,
  output logic recording_q,
  // flash record write
  output logic flash_wr_valid_q,
  input wire logic flash_wr_ready,
  output log_entry_s flash_wr_entry_q,
  // flash erase
  output logic flash_erase_q,
  input wire logic flash_erase_done,
  // flash record read
  output logic flash_rd_req_q,
  output idx_t flash_rd_addr_q,
  input wire logic flash_rd_valid,
  input wire record_s flash_rd_data,
  // readout stream to host
  output logic rec_out_valid_q,
  input wire logic rec_out_ready,
  output record_s rec_out_q,
  output logic read_done_q,
  // persistent state store
  input wire logic nv_load_valid,
  input wire persist_s nv_load,
  output logic nv_save_q,
  output persist_s nv_data_q
);

  localparam idx_t MAX_IDX = idx_t'(MAX_REC);
  localparam idx_t LAST_IDX = idx_t'(MAX_REC - 1);

  typedef struct packed {
    st_e st;
    persist_s p;
    chan_t meas;
    chan_t last_rec;
    logic start_pend;
    logic stop_pend;
    chan_t chan_on;
    chan_t led_on;
    logic span_mode;
    stamp_t span_lo;
    stamp_t span_hi;
    idx_t rd_addr;
    idx_t rd_left;
    logic rd_req;
    logic erase_req;
    logic cmd_ready;
    logic out_valid;
    record_s out_rec;
    logic done;
    logic pushed;
    logic nv_save;
    persist_s nv_data;
  } ctl_s;

  ctl_s s, n;
  logic push;
  logic log_want;
  logic full;
  logic cmd_take;
  log_entry_s entry;
  logic log_in_ready;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic idx_t next_idx(input idx_t i);
    next_idx = (i == LAST_IDX) ? IDX_ZERO : i + IDX_ONE;
  endfunction

  function automatic chan_t drive_of(input chan_t src, input chan_t meas, input chan_t host);
    drive_of = (src & meas) | (~src & host);
  endfunction

  // ************************************************************
  // control
  // ************************************************************
  always_comb begin
    n = s;
    push = 1'b0;
    entry = '0;
    n.done = 1'b0;
    n.rd_req = 1'b0;
    cmd_take = cmd_valid && s.cmd_ready && (s.st == ST_IDLE);
    full = (s.p.count == MAX_IDX);
    if (meas_valid) begin
      n.meas = meas_bits;
    end
    n.chan_on = drive_of(s.p.src_meas, s.meas, s.p.host_out); // R1 R2
    n.led_on = n.chan_on; // R3
    // a change against the last record triggers a new one
    log_want = s.start_pend || s.stop_pend || (s.p.rec_on && (s.chan_on != s.last_rec)); // R4 R13
    // records are held while the erase request is raised, so none reaches a store being wiped
    if (log_want && (s.st != ST_RESTORE) && !s.erase_req) begin
      if (full && (s.p.policy == END_STOP_FULL)) begin
        n.p.rec_on = 1'b0; // R8
        n.start_pend = 1'b0;
        n.stop_pend = 1'b0;
      end else if (log_in_ready) begin
        push = 1'b1;
        entry.addr = s.p.wr_ptr; // R7
        entry.rec.stamp = time_now; // R6
        entry.rec.state = s.chan_on;
        n.last_rec = s.chan_on;
        n.start_pend = 1'b0;
        n.stop_pend = 1'b0;
        n.p.wr_ptr = next_idx(s.p.wr_ptr); // R9
        if (!full) begin
          n.p.count = s.p.count + IDX_ONE;
        end
      end
    end
    n.pushed = push;
    unique case (s.st)
      ST_RESTORE: begin
        if (nv_load_valid) begin
          n.p = nv_load; // R12
          n.last_rec = drive_of(nv_load.src_meas, s.meas, nv_load.host_out);
          // outputs resume at once, so resuming is not taken for a change
          n.chan_on = n.last_rec; // R12
          n.led_on = n.last_rec;
          n.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cmd_take) begin
          unique case (cmd.code)
            CMD_SET_OUT: n.p.host_out = cmd.arg_a[NUM_CH-1:0]; // R1
            CMD_SET_SRC: n.p.src_meas = cmd.arg_a[NUM_CH-1:0];
            CMD_SET_END: begin
              // policy is frozen while a session runs
              if (!s.p.rec_on) begin
                n.p.policy = end_e'(cmd.arg_a[0]); // R8
              end
            end
            CMD_START: begin
              if (!s.p.rec_on) begin
                n.p.rec_on = 1'b1; // R5
                n.start_pend = 1'b1;
                n.stop_pend = 1'b0;
              end
            end
            CMD_STOP: begin
              if (s.p.rec_on) begin
                n.p.rec_on = 1'b0;
                n.stop_pend = 1'b1;
              end
            end
            CMD_ERASE: n.st = ST_ERASE; // R11
            CMD_READ_ALL, CMD_READ_SPAN: begin
              n.span_mode = (cmd.code == CMD_READ_SPAN); // R10
              n.span_lo = cmd.arg_a;
              n.span_hi = cmd.arg_b;
              n.rd_left = s.p.count;
              n.rd_addr = full ? s.p.wr_ptr : IDX_ZERO;
              n.st = ST_READ_REQ;
            end
            CMD_READ_STATUS: begin
              n.out_valid = 1'b1; // R10
              n.out_rec.stamp = time_now;
              n.out_rec.state = s.chan_on;
              n.rd_left = IDX_ZERO;
              n.st = ST_READ_OUT;
            end
            default: ;
          endcase
        end
      end
      ST_ERASE: begin
        // wait until queued records have reached flash before wiping it
        if (!s.erase_req) begin
          // a record pushed last cycle is in the queue but not yet at its output
          n.erase_req = !flash_wr_valid_q && !log_want && !s.pushed;
        end else if (flash_erase_done) begin
          n.erase_req = 1'b0;
          n.p.wr_ptr = IDX_ZERO; // R11
          n.p.count = IDX_ZERO;
          n.st = ST_IDLE;
        end
      end
      ST_READ_REQ: begin
        if (s.rd_left == IDX_ZERO) begin
          n.done = 1'b1;
          n.st = ST_IDLE;
        end else begin
          n.rd_req = 1'b1;
          n.st = ST_READ_WAIT;
        end
      end
      ST_READ_WAIT: begin
        if (flash_rd_valid) begin
          n.rd_addr = next_idx(s.rd_addr);
          n.rd_left = s.rd_left - IDX_ONE;
          if (!s.span_mode || ((flash_rd_data.stamp >= s.span_lo) && (flash_rd_data.stamp <= s.span_hi))) begin
            n.out_valid = 1'b1; // R10
            n.out_rec = flash_rd_data;
            n.st = ST_READ_OUT;
          end else begin
            n.st = ST_READ_REQ;
          end
        end
      end
      ST_READ_OUT: begin
        if (rec_out_ready) begin
          n.out_valid = 1'b0;
          n.st = ST_READ_REQ;
        end
      end
    endcase
    n.cmd_ready = (n.st == ST_IDLE);
    n.nv_save = (n.p != s.p); // R12
    n.nv_data = n.p;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ************************************************************
  // record queue toward flash
  // ************************************************************
  sync_fifo #(
    .WIDTH($bits(log_entry_s)),
    .DEPTH(LOG_FIFO_DEPTH)
  ) u_log_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(log_in_ready),
    .in_data(entry),
    .out_valid(flash_wr_valid_q),
    .out_ready(flash_wr_ready),
    .out_data(flash_wr_entry_q)
  );

  assign cmd_ready_q = s.cmd_ready;
  assign channel_on_q = s.chan_on;
  assign led_on_q = s.led_on;
  assign recording_q = s.p.rec_on;
  assign flash_erase_q = s.erase_req;
  assign flash_rd_req_q = s.rd_req;
  assign flash_rd_addr_q = s.rd_addr;
  assign rec_out_valid_q = s.out_valid;
  assign rec_out_q = s.out_rec;
  assign read_done_q = s.done;
  assign nv_save_q = s.nv_save;
  assign nv_data_q = s.nv_data;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic take_out, take_drive;
  assign take_out = cmd_take && (cmd.code == CMD_SET_OUT) && (s.p.src_meas == '0);
  assign take_drive = cmd_take && ((cmd.code == CMD_SET_OUT) || (cmd.code == CMD_SET_SRC));

  host_drive_a: assert property (take_out ##1 !take_drive |-> ##1 channel_on_q == $past(cmd.arg_a[NUM_CH-1:0], 2)) // R1 R2
    else $error("channel drive does not follow host command");
  led_follow_a: assert property (led_on_q == channel_on_q) // R3
    else $error("indicator differs from channel switch");
  log_cause_a: assert property (push |-> s.start_pend || s.stop_pend || (s.chan_on != s.last_rec)) // R4 R13
    else $error("record written without event");
  start_cause_a: assert property ($rose(recording_q) |-> $past(cmd_take && cmd.code == CMD_START) || $past(s.st == ST_RESTORE)) // R5
    else $error("recording began without start command");
  record_fields_a: assert property (push |-> entry.rec.stamp == time_now && entry.rec.state == channel_on_q) // R6
    else $error("record content wrong");
  append_ptr_a: assert property (push |=> s.p.wr_ptr == next_idx($past(s.p.wr_ptr))) // R7
    else $error("write pointer did not advance");
  full_stop_a: assert property (s.p.policy == END_STOP_FULL && full |-> !push) // R8 R9
    else $error("record written to full store");
  count_bound_a: assert property (s.p.count <= MAX_IDX) // R9
    else $error("record count above capacity");
  span_filter_a: assert property ($rose(s.out_valid) && s.st == ST_READ_OUT && $past(s.st == ST_READ_WAIT) && s.span_mode
      |-> rec_out_q.stamp >= s.span_lo && rec_out_q.stamp <= s.span_hi) // R10
    else $error("record outside requested span");
  erase_clear_a: assert property (s.st == ST_ERASE && s.erase_req && flash_erase_done |=> s.p.count == IDX_ZERO
      && s.p.wr_ptr == IDX_ZERO && cmd_ready_q) // R11
    else $error("erase did not empty store");
  restore_state_a: assert property (s.st == ST_RESTORE && nv_load_valid |=> s.p == $past(nv_load) && cmd_ready_q
      && channel_on_q == s.last_rec) // R12
    else $error("state not restored after power return");
  nv_save_a: assert property ($changed(nv_data_q) |-> nv_save_q) // R12
    else $error("changed state not offered for saving");

  start_seen_c: cover property (cmd_take && cmd.code == CMD_START ##[1:8] push);
  read_done_c: cover property (s.span_mode && read_done_q);
  erase_done_c: cover property (s.st == ST_ERASE ##1 s.st == ST_IDLE);
  fifo_stall_c: cover property (log_want && !log_in_ready);
endmodule
`default_nettype wire

// ### core/output_state_event_logger_pkg.sv
// shared constants and types for the output state event logger
package output_state_event_logger_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NUM_CH = 8;
  localparam int TIME_W = 32;
  localparam int FLASH_BYTES = 512 * 1024;
  localparam int MAX_RECORDS = 30000;
  localparam int IDX_W = 15;
  localparam int FIFO_DEPTH = 32;
  localparam int RECORD_BYTES = (TIME_W + NUM_CH) / 8;

  typedef logic [NUM_CH-1:0] chan_t;
  typedef logic [TIME_W-1:0] stamp_t;
  typedef logic [IDX_W-1:0] idx_t;

  localparam idx_t IDX_ZERO = 15'h0000;
  localparam idx_t IDX_ONE = 15'h0001;

  // ************************************************************
  // commands, policies, states
  // ************************************************************
  typedef enum logic [3:0] {
    CMD_SET_OUT,
    CMD_SET_SRC,
    CMD_SET_END,
    CMD_START,
    CMD_STOP,
    CMD_ERASE,
    CMD_READ_ALL,
    CMD_READ_SPAN,
    CMD_READ_STATUS
  } cmd_e;

  typedef enum logic {
    END_STOP_FULL,
    END_INDEFINITE
  } end_e;

  typedef enum logic [2:0] {
    ST_RESTORE,
    ST_IDLE,
    ST_ERASE,
    ST_READ_REQ,
    ST_READ_WAIT,
    ST_READ_OUT
  } st_e;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    cmd_e code;
    stamp_t arg_a;
    stamp_t arg_b;
  } cmd_s;

  typedef struct packed {
    stamp_t stamp;
    chan_t state;
  } record_s;

  typedef struct packed {
    idx_t addr;
    record_s rec;
  } log_entry_s;

  typedef struct packed {
    logic rec_on;
    end_e policy;
    chan_t src_meas;
    chan_t host_out;
    idx_t wr_ptr;
    idx_t count;
  } persist_s;

endpackage

// ### core/sync_fifo.sv
// synchronous fifo with registered output stage
`timescale 1ns/1ps
`default_nettype none
module sync_fifo
  import output_state_event_logger_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // depth must be a power of two so pointers wrap by themselves
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [PTR_W:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } fifo_state_s;

  logic [WIDTH-1:0] mem [DEPTH];
  fifo_state_s s_q, s_d;
  logic push, pop;

  assign in_ready = (s_q.cnt != CNT_FULL);
  assign out_valid = s_q.ov;
  assign out_data = s_q.od;

  always_comb begin
    s_d = s_q;
    push = in_valid && in_ready;
    pop = (s_q.cnt != '0) && (!s_q.ov || out_ready);
    if (s_q.ov && out_ready) begin
      s_d.ov = 1'b0;
    end
    if (pop) begin
      s_d.ov = 1'b1;
      s_d.od = mem[s_q.rd];
      s_d.rd = s_q.rd + 1'b1;
    end
    if (push) begin
      s_d.wr = s_q.wr + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage carries no reset; only written slots are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_q.wr] <= in_data;
    end
  end

  fifo_count_a: assert property (@(posedge clk) disable iff (!reset_n) s_q.cnt <= CNT_FULL)
    else $error("fifo count above depth");
endmodule
`default_nettype wire

// ### test/flash_store_model.sv
// behavioural flash store facing the logger's record, erase and read ports
`timescale 1ns/1ps
`default_nettype none
module flash_store_model
  import output_state_event_logger_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pacing
  input wire logic slow,
  // record write
  input wire logic wr_valid,
  output logic wr_ready,
  input wire log_entry_s wr_entry,
  output logic [15:0] wr_cnt,
  // erase
  input wire logic erase,
  output logic erase_done,
  // read
  input wire logic rd_req,
  input wire idx_t rd_addr,
  output logic rd_valid,
  output record_s rd_data
);
  // ************************************************************
  // store
  // ************************************************************
  // contents and write count survive reset, as flash does
  record_s mem [0:31];
  logic [2:0] rd_wait, er_wait;
  logic tick;
  idx_t rd_a;
  initial wr_cnt = 16'h0000;
  assign wr_ready = reset_n && (!slow || tick);
  always @(posedge clk) begin
    if (wr_valid && wr_ready) begin
      mem[wr_entry.addr[4:0]] <= wr_entry.rec;
      wr_cnt <= wr_cnt + 16'h0001;
    end
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick <= 1'b0;
      rd_wait <= 3'h0;
      er_wait <= 3'h0;
      rd_valid <= 1'b0;
      erase_done <= 1'b0;
      rd_data <= '0;
      rd_a <= '0;
    end else begin
      tick <= !tick;
      rd_valid <= 1'b0;
      erase_done <= 1'b0;
      // no stale data between answers
      rd_data <= ~rd_data;
      if (rd_req) begin
        rd_a <= rd_addr;
        rd_wait <= slow ? 3'h4 : 3'h1;
      end else if (rd_wait == 3'h1) begin
        rd_valid <= 1'b1;
        rd_data <= mem[rd_a[4:0]];
        rd_wait <= 3'h0;
      end else if (rd_wait != 3'h0) begin
        rd_wait <= rd_wait - 3'h1;
      end
      if (erase && !erase_done) begin
        er_wait <= er_wait + 3'h1;
        if (er_wait == 3'h5) begin
          erase_done <= 1'b1;
          er_wait <= 3'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### test/output_state_event_logger_tb.sv
// self-checking bench for the output state event logger
`timescale 1ns/1ps
`default_nettype none
module output_state_event_logger_tb;
  import output_state_event_logger_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, meas_valid = 1'b0, nv_load_valid = 1'b0;
  logic slow = 1'b0, rec_out_ready = 1'b1;
  cmd_s cmd = '0;
  chan_t meas_bits = '0;
  stamp_t time_now = '0;
  persist_s nv_load = '0;
  chan_t channel_on_q, led_on_q;
  logic cmd_ready_q, recording_q, flash_wr_valid_q, flash_wr_ready, flash_erase_q, flash_erase_done;
  logic flash_rd_req_q, flash_rd_valid, rec_out_valid_q, read_done_q, nv_save_q;
  log_entry_s flash_wr_entry_q, last;
  idx_t flash_rd_addr_q;
  record_s flash_rd_data, rec_out_q, first;
  persist_s nv_data_q;
  logic [15:0] wr_cnt, w0;
  int mismatches = 0, checks = 0, n;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    time_now <= time_now + 32'h00000001;
    rec_out_ready <= slow ? ~rec_out_ready : 1'b1;
    if (flash_wr_valid_q === 1'b1 && flash_wr_ready === 1'b1) last <= flash_wr_entry_q;
  end
  output_state_event_logger #(.MAX_REC(8), .LOG_FIFO_DEPTH(FIFO_DEPTH)) uut (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_q(cmd_ready_q), .meas_valid(meas_valid),
    .meas_bits(meas_bits), .time_now(time_now), .channel_on_q(channel_on_q), .led_on_q(led_on_q),
    .recording_q(recording_q), .flash_wr_valid_q(flash_wr_valid_q), .flash_wr_ready(flash_wr_ready),
    .flash_wr_entry_q(flash_wr_entry_q), .flash_erase_q(flash_erase_q), .flash_erase_done(flash_erase_done),
    .flash_rd_req_q(flash_rd_req_q), .flash_rd_addr_q(flash_rd_addr_q), .flash_rd_valid(flash_rd_valid),
    .flash_rd_data(flash_rd_data), .rec_out_valid_q(rec_out_valid_q), .rec_out_ready(rec_out_ready),
    .rec_out_q(rec_out_q), .read_done_q(read_done_q), .nv_load_valid(nv_load_valid), .nv_load(nv_load),
    .nv_save_q(nv_save_q), .nv_data_q(nv_data_q));
  flash_store_model flash (.clk(clk), .reset_n(reset_n), .slow(slow), .wr_valid(flash_wr_valid_q),
    .wr_ready(flash_wr_ready), .wr_entry(flash_wr_entry_q), .wr_cnt(wr_cnt), .erase(flash_erase_q),
    .erase_done(flash_erase_done), .rd_req(flash_rd_req_q), .rd_addr(flash_rd_addr_q),
    .rd_valid(flash_rd_valid), .rd_data(flash_rd_data));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_ready();
    @(negedge clk);
    for (int i = 0; i < 3000 && cmd_ready_q !== 1'b1; i++) @(negedge clk);
    chk("cmd_ready_q", 40'h1, cmd_ready_q);
  endtask
  task automatic send(input cmd_e c, input stamp_t a, input stamp_t b);
    wait_ready();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{c, a, b};
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic settle();
    repeat (16) @(posedge clk);
    wait_ready();
  endtask
  task automatic meas(input chan_t m);
    @(posedge clk);
    meas_bits <= m;
    meas_valid <= 1'b1;
    @(posedge clk);
    meas_valid <= 1'b0;
  endtask
  task automatic restore(input persist_s p);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    nv_load <= p;
    nv_load_valid <= 1'b1;
    @(posedge clk);
    nv_load_valid <= 1'b0;
    w0 = wr_cnt;
    settle();
  endtask
  task automatic readout(input cmd_e c, input stamp_t a, input stamp_t b);
    send(c, a, b);
    n = 0;
    for (int i = 0; i < 3000 && read_done_q !== 1'b1; i++) begin
      @(posedge clk);
      if (rec_out_valid_q === 1'b1 && rec_out_ready === 1'b1) begin
        if (n == 0) first = rec_out_q;
        n++;
      end
    end
    chk("read_done_q", 40'h1, read_done_q);
    settle();
  endtask
  task automatic toggles(input int k);
    for (int i = 0; i < k; i++) begin
      send(CMD_SET_OUT, (i % 2 == 0) ? 32'h000000FF : 32'h00000000, 32'h0);
      settle();
    end
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_blank();
    restore('0);
    chk("recording_q", 40'h0, recording_q);
    chk("writes", 40'h0, wr_cnt - w0);
  endtask
  task automatic t_drive();
    send(CMD_SET_OUT, 32'h000000A5, 32'h0);
    settle();
    chk("channel_on_q", 40'hA5, channel_on_q);
    chk("led_on_q", 40'hA5, led_on_q);
    chk("nv_data_q", 40'hA5, nv_data_q.host_out);
    meas(8'h3C);
    send(CMD_SET_SRC, 32'h0000000F, 32'h0);
    settle();
    chk("channel_on_q", 40'hAC, channel_on_q);
  endtask
  task automatic t_log();
    w0 = wr_cnt;
    send(CMD_START, 32'h0, 32'h0);
    settle();
    chk("writes", 40'h1, wr_cnt - w0);
    chk("state", 40'hAC, last.rec.state);
    chk("addr", 40'h0, last.addr);
    meas(8'h3D);
    settle();
    chk("writes", 40'h2, wr_cnt - w0);
    chk("state", 40'hAD, last.rec.state);
    send(CMD_STOP, 32'h0, 32'h0);
    settle();
    chk("writes", 40'h3, wr_cnt - w0);
    chk("recording_q", 40'h0, recording_q);
    slow = 1'b1;
    send(CMD_START, 32'h0, 32'h0);
    send(CMD_STOP, 32'h0, 32'h0);
    settle();
    chk("addr", 40'h4, last.addr);
  endtask
  task automatic t_read();
    readout(CMD_READ_STATUS, 32'h0, 32'h0);
    chk("status beats", 40'h1, n);
    chk("status", 40'hAD, first.state);
    readout(CMD_READ_ALL, 32'h0, 32'h0);
    chk("all beats", 40'h5, n);
    chk("oldest", 40'hAC, first.state);
    readout(CMD_READ_SPAN, 32'hFFFFFFF0, 32'hFFFFFFFF);
    chk("span beats", 40'h0, n);
    readout(CMD_READ_SPAN, 32'h0, 32'hFFFFFFFF);
    chk("span beats", 40'h5, n);
    slow = 1'b0;
  endtask
  task automatic t_end();
    send(CMD_ERASE, 32'h0, 32'h0);
    readout(CMD_READ_ALL, 32'h0, 32'h0);
    chk("erased beats", 40'h0, n);
    send(CMD_SET_END, 32'h0, 32'h0);
    w0 = wr_cnt;
    send(CMD_START, 32'h0, 32'h0);
    toggles(10);
    chk("writes", 40'h8, wr_cnt - w0);
    chk("recording_q", 40'h0, recording_q);
    send(CMD_ERASE, 32'h0, 32'h0);
    send(CMD_SET_END, 32'h1, 32'h0);
    w0 = wr_cnt;
    send(CMD_START, 32'h0, 32'h0);
    toggles(10);
    chk("writes", 40'h0B, wr_cnt - w0);
    chk("recording_q", 40'h1, recording_q);
  endtask
  task automatic t_power();
    restore('{1'b1, END_INDEFINITE, 8'h00, 8'h33, 15'h0003, 15'h0003});
    chk("channel_on_q", 40'h33, channel_on_q);
    chk("recording_q", 40'h1, recording_q);
    chk("writes", 40'h0, wr_cnt - w0);
    readout(CMD_READ_ALL, 32'h0, 32'h0);
    chk("kept beats", 40'h3, n);
  endtask
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
  initial begin
    t_blank();
    t_drive();
    t_log();
    t_read();
    t_end();
    t_power();
    summarize();
  end
endmodule
`default_nettype wire
